//--- dv/mid_decoder_assertions.sv
// mid_decoder_assertions.sv: cycle, flag and handshake checks on decoder ports
// assumes: bound into mid_decoder, single clock domain, sync reset
`timescale 1ns/1ns
`default_nettype none
`include "mid_regs.vh"
module mid_decoder_checker
#(
    parameter PC_W = 12
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic prog_ready,
    input wire logic [PC_W-1:0] pc_q,
    input wire logic exec_go_q,
    input wire logic [2:0] exec_cls_q,
    input wire logic [4:0] exec_op_q,
    input wire logic exec_z_upd_q,
    input wire logic exec_c_upd_q,
    input wire logic flag_z_q,
    input wire logic flag_c_q,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    wire logic rel_go = exec_go_q && exec_op_q == `MID_OP_REL_BRANCH;
    wire logic bit_go = exec_go_q && (exec_op_q == `MID_OP_BIT_CLR_BR
        || exec_op_q == `MID_OP_BIT_SET_BR);
    wire logic bump_go = exec_go_q && (exec_op_q == `MID_OP_BUMP_UP
        || exec_op_q == `MID_OP_BUMP_DOWN);
    wire logic four_go = bump_go || exec_go_q && (exec_op_q == `MID_OP_ADD
        || exec_op_q == `MID_OP_MOVE_ACCUM || exec_op_q == `MID_OP_CALL);
    // busy covers the op's cycles plus the go cycle
    sequence s_busy3;
        busy [*3] ##1 !busy;
    endsequence
    sequence s_busy5;
        busy [*5] ##1 !busy;
    endsequence
    sequence s_busy6;
        busy [*6] ##1 !busy;
    endsequence
    property p_reset_vals;
        disable iff (1'b0)
        reset |=> pc_q == '0 && exec_cls_q == `MID_CLS_BAD && !busy && !flag_z_q && !flag_c_q;
    endproperty
    AST_RESET_VALS: assert property (p_reset_vals)
        else $error("decoder state wrong after reset");
    AST_READY_IDLE: assert property (prog_ready != busy)
        else $error("prog_ready not the inverse of busy");
    AST_GO_ONE: assert property (exec_go_q |=> !exec_go_q)
        else $error("exec_go_q longer than one cycle");
    AST_REL_CYC: assert property (rel_go |-> s_busy3)
        else $error("relative branch busy length wrong");
    AST_REL_FLAGS: assert property (rel_go |-> !exec_z_upd_q && !exec_c_upd_q
        ##1 ($stable(flag_z_q) && $stable(flag_c_q)) [*3])
        else $error("relative branch touched flags");
    AST_FOUR_CYC: assert property (four_go |-> s_busy5)
        else $error("four-cycle op busy length wrong");
    AST_BUMP_CARRY: assert property (bump_go |-> exec_z_upd_q && !exec_c_upd_q
        ##1 $stable(flag_c_q) [*5])
        else $error("bump changed carry");
    AST_BUSY_PC: assert property (bump_go |=> $stable(pc_q) [*4])
        else $error("byte taken while busy");
    AST_BIT_CYC: assert property (bit_go |-> s_busy6)
        else $error("bit branch busy length wrong");
    AST_BIT_FLAGS: assert property (bit_go |-> exec_c_upd_q && !exec_z_upd_q
        ##1 $stable(flag_z_q) [*6])
        else $error("bit branch flag marks wrong");
    // a bit branch loads carry on the edge that takes its third byte, before busy
    AST_IDLE_FLAGS: assert property (!busy |=> $stable(flag_z_q) && ($stable(flag_c_q) || bit_go))
        else $error("flags changed while idle");
endmodule
bind mid_decoder mid_decoder_checker #(.PC_W(PC_W)) mid_decoder_checker_inst (
    .ref_clk(ref_clk), .reset(reset), .prog_ready(prog_ready), .pc_q(pc_q),
    .exec_go_q(exec_go_q), .exec_cls_q(exec_cls_q), .exec_op_q(exec_op_q),
    .exec_z_upd_q(exec_z_upd_q), .exec_c_upd_q(exec_c_upd_q),
    .flag_z_q(flag_z_q), .flag_c_q(flag_c_q), .busy(busy));
`default_nettype wire

//--- dv/mid_decoder_tb.sv
// mid_decoder_tb.sv: self-checking random bench for the decoder
// assumes: opcodes follow the core map; the bench plays datapath and memory
`timescale 1ns/1ns
`default_nettype none
`include "mid_regs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mid_decoder_tb;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] prog_data = 8'h00;
    logic prog_valid = 1'b0;
    logic tested_bit = 1'b0;
    logic exec_z = 1'b0;
    logic exec_c = 1'b0;
    logic exec_z_wr = 1'b0;
    logic exec_c_wr = 1'b0;
    wire logic prog_ready;
    wire logic [11:0] pc_q;
    wire logic exec_go_q;
    wire logic [2:0] exec_cls_q;
    wire logic [4:0] exec_op_q;
    wire logic [2:0] exec_src_q;
    wire logic [7:0] exec_addr_q;
    wire logic [7:0] exec_imm_q;
    wire logic [2:0] exec_bit_q;
    wire logic [11:0] exec_target_q;
    wire logic exec_z_upd_q;
    wire logic exec_c_upd_q;
    wire logic flag_z_q;
    wire logic flag_c_q;
    wire logic busy;
    int miscompares = 0;
    int checked = 0;
    int seed = 70511;
    int nbusy;
    int cyc_cnt = 0;
    int k;
    logic [11:0] epc = 12'h000;
    logic fz = 1'b0;
    logic fc = 1'b0;
    logic tk;
    logic dir;
    logic [31:0] r;
    mid_decoder #(.PC_W(12)) mid_decoder_inst (
        .ref_clk(ref_clk), .reset(reset), .prog_data(prog_data), .prog_valid(prog_valid),
        .tested_bit(tested_bit), .exec_z(exec_z), .exec_c(exec_c), .exec_z_wr(exec_z_wr),
        .exec_c_wr(exec_c_wr), .prog_ready(prog_ready), .pc_q(pc_q), .exec_go_q(exec_go_q),
        .exec_cls_q(exec_cls_q), .exec_op_q(exec_op_q), .exec_src_q(exec_src_q),
        .exec_addr_q(exec_addr_q), .exec_imm_q(exec_imm_q), .exec_bit_q(exec_bit_q),
        .exec_target_q(exec_target_q), .exec_z_upd_q(exec_z_upd_q),
        .exec_c_upd_q(exec_c_upd_q), .flag_z_q(flag_z_q), .flag_c_q(flag_c_q), .busy(busy));
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // worst case is well under 100 cycles per loop pass
    always @(posedge ref_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    function automatic logic taken_rel(input logic [1:0] cnd, input logic z, input logic c);
        return cnd[0] ? (c == cnd[1]) : (z == cnd[1]);
    endfunction
    // feeds one instruction back to back, then offers junk that must be refused
    task automatic xo(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
        input int n, input int cyc, input logic zv, input logic cv, input logic tbit,
        input logic [2:0] cls, input logic [4:0] opc, input logic [11:0] npc,
        input logic ez, input logic ec);
        int i;
        int g;
        for (i = 0; i < n; i++)
        begin
            @(negedge ref_clk);
            prog_data = (i == 0) ? b0 : (i == 1) ? b1 : b2;
            prog_valid = 1'b1;
            tested_bit = tbit;
            g = 0;
            while (prog_ready !== 1'b1 && g < 20)
            begin
                @(negedge ref_clk);
                g++;
            end
        end
        @(negedge ref_clk);
        exec_z = zv;
        exec_c = cv;
        exec_z_wr = 1'b1;
        exec_c_wr = 1'b1;
        `CHK(exec_go_q, 1'b1)
        `CHK(exec_cls_q, cls)
        `CHK(exec_op_q, opc)
        nbusy = 0;
        while (busy === 1'b1 && nbusy < 20)
        begin
            nbusy++;
            prog_data = 8'($random(seed));
            @(negedge ref_clk);
        end
        prog_valid = 1'b0;
        exec_z_wr = 1'b0;
        exec_c_wr = 1'b0;
        `CHK(nbusy, cyc + 1)
        `CHK(pc_q, npc)
        `CHK(flag_z_q, ez)
        `CHK(flag_c_q, ec)
        epc = npc;
        fz = ez;
        fc = ec;
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        `CHK(pc_q, 12'h000)
        `CHK(exec_cls_q, `MID_CLS_BAD)
        `CHK(prog_ready, 1'b1)
        r = $random(seed);
        xo(8'h47, 8'h00, 8'h00, 1, 4, r[0], r[1], 1'b0, `MID_CLS_ALU, `MID_OP_ADD,
            epc + 12'h001, r[0], r[1]);
        `CHK(exec_src_q, `MID_SRC_INDIRECT)
        xo(8'h15, 8'h00, 8'h00, 1, 4, ~fz, ~fc, 1'b0, `MID_CLS_ALU, `MID_OP_BUMP_UP,
            epc + 12'h001, ~fz, fc);
        `CHK(exec_addr_q, `MID_ADDR_X)
        xo(8'h05, 8'h00, 8'h00, 1, 4, ~fz, ~fc, 1'b0, `MID_CLS_LDST, `MID_OP_MOVE_ACCUM,
            epc + 12'h001, ~fz, fc);
        `CHK(exec_src_q, `MID_SRC_SHORT)
        xo(8'h17, r[15:8], 8'h00, 2, 4, ~fz, ~fc, 1'b0, `MID_CLS_LDST,
            `MID_OP_MOVE_IMMEDIATE, epc + 12'h002, ~fz, fc);
        `CHK(exec_imm_q, r[15:8])
        xo({r[27:24], 4'h1}, r[23:16], 8'h00, 2, 4, ~fz, ~fc, 1'b0, `MID_CLS_JMP,
            `MID_OP_CALL, r[27:16], fz, fc);
        `CHK(exec_target_q, r[27:16])
        for (k = 0; k < 40; k++)
        begin
            r = $random(seed);
            xo(8'h47, 8'h00, 8'h00, 1, 4, r[0], r[1], 1'b0, `MID_CLS_ALU, `MID_OP_ADD,
                epc + 12'h001, r[0], r[1]);
            if (r[2])
            begin
                tk = taken_rel(r[4:3], fz, fc);
                dir = tk ? 1'b0 : r[5];
                // opcode 04 decodes as the no-operation, not a branch
                if ({r[9:6], dir, r[4:3]} == 7'h02)
                    r[6] = 1'b1;
                xo({r[9:6], dir, r[4:3], 1'b0}, 8'h00, 8'h00, 1, 2, ~fz, ~fc, 1'b0,
                    `MID_CLS_BRANCH, `MID_OP_REL_BRANCH,
                    epc + 12'h001 + (tk ? {8'h00, r[9:6]} : 12'h000), fz, fc);
            end
            else
            begin
                // taken when the tested bit equals the set/clear select
                tk = (r[10] == r[11]);
                xo({r[14:12], r[11], 4'h3}, r[23:16], r[31:24], 3, 5, ~fz, r[10], r[10],
                    `MID_CLS_BRANCH, r[11] ? `MID_OP_BIT_SET_BR : `MID_OP_BIT_CLR_BR,
                    epc + 12'h003 + (tk ? {{4{r[31]}}, r[31:24]} : 12'h000), fz, r[10]);
                `CHK(exec_bit_q, r[14:12])
                `CHK(exec_addr_q, r[23:16])
            end
        end
        repeat (3) @(negedge ref_clk);
        report_and_stop();
    end
endmodule
`default_nettype wire

//--- rtl/mid_cycle_timer.v
// mid_cycle_timer.v: counts execution cycles of one instruction
// assumes: start pulses only while idle
`timescale 1ns/1ns
`default_nettype none

module mid_cycle_timer
(
    input wire ref_clk,
    input wire reset,
    input wire start,
    input wire [2:0] cycles,
    output wire busy,
    output wire last
);
    reg [2:0] count_q;
    reg [2:0] count_d;

    assign busy = (count_q != 3'h0);
    assign last = (count_q == 3'h1);

    always @*
    begin
        count_d = count_q;
        if (start)
            count_d = cycles;
        else if (busy)
            count_d = count_q - 3'h1;
    end

    always @(posedge ref_clk)
    begin
        if (reset)
            count_q <= 3'h0;
        else
            count_q <= count_d;
    end
endmodule

`default_nettype wire

//--- rtl/mid_decoder.v
// mid_decoder.v: fetch-and-decode sequencer for the 8-bit core
// assumes: program bytes arrive with prog_valid, one per cycle at most;
// the datapath executes exec_* and returns the flags and tested bit
`timescale 1ns/1ns
`default_nettype none

module mid_decoder
#(
    parameter PC_W = 12
)
(
    input wire ref_clk,
    input wire reset,
    input wire [7:0] prog_data,
    input wire prog_valid,
    input wire tested_bit,
    input wire exec_z,
    input wire exec_c,
    input wire exec_z_wr,
    input wire exec_c_wr,
    output wire prog_ready,
    output reg [PC_W-1:0] pc_q,
    output reg exec_go_q,
    output reg [2:0] exec_cls_q,
    output reg [4:0] exec_op_q,
    output reg [2:0] exec_src_q,
    output reg [7:0] exec_addr_q,
    output reg [7:0] exec_imm_q,
    output reg [2:0] exec_bit_q,
    output reg [PC_W-1:0] exec_target_q,
    output reg exec_z_upd_q,
    output reg exec_c_upd_q,
    output reg flag_z_q,
    output reg flag_c_q,
    output wire busy
);
`include "mid_regs.vh"

    localparam ST_OPCODE = 2'h0;
    localparam ST_BYTE2 = 2'h1;
    localparam ST_BYTE3 = 2'h2;
    localparam ST_EXEC = 2'h3;

    reg [1:0] state_q;
    reg [7:0] opc_q;
    reg [7:0] b2_q;
    reg [1:0] len_q;
    reg [2:0] cyc_q;
    reg [2:0] cls_q;
    reg [4:0] op_q;
    reg [2:0] src_q;
    reg z_upd_q;
    reg c_upd_q;
    reg [PC_W-1:0] start_pc_q;
    reg timer_start_q;

    wire [2:0] t_cls;
    wire [4:0] t_op;
    wire [2:0] t_src;
    wire [1:0] t_len;
    wire [2:0] t_cyc;
    wire t_z_upd;
    wire t_c_upd;
    wire t_busy;
    wire t_last;

    mid_opcode_table mid_opcode_table_inst
    (
        .opcode(prog_data),
        .cls(t_cls),
        .op(t_op),
        .src(t_src),
        .len(t_len),
        .cycles(t_cyc),
        .z_upd(t_z_upd),
        .c_upd(t_c_upd)
    );

    mid_cycle_timer mid_cycle_timer_inst
    (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(timer_start_q),
        .cycles(cyc_q),
        .busy(t_busy),
        .last(t_last)
    );

    assign prog_ready = (state_q != ST_EXEC);
    assign busy = (state_q == ST_EXEC);

    wire take = prog_valid && prog_ready;

    // relative branch fields: condition in opcode bits 2:1, span in bits 7:3
    wire [1:0] rel_cond = opc_q[2:1];
    wire rel_true = (rel_cond == `MID_COND_ZCLR) ? !flag_z_q :
                    (rel_cond == `MID_COND_CCLR) ? !flag_c_q :
                    (rel_cond == `MID_COND_ZSET) ? flag_z_q : flag_c_q;
    // 5-bit signed span: bit 3 backward, 4 bits of size, forward adds one
    wire [PC_W-1:0] rel_span = {{(PC_W-4){1'b0}}, opc_q[7:4]};
    wire [PC_W-1:0] rel_fwd = start_pc_q + rel_span + {{(PC_W-1){1'b0}}, 1'b1};
    wire [PC_W-1:0] rel_back = start_pc_q - rel_span;
    wire [PC_W-1:0] rel_dest = opc_q[3] ? rel_back : rel_fwd;
    // bit-test displacement is a signed byte from the third byte
    wire [PC_W-1:0] bt_disp = {{(PC_W-8){prog_data[7]}}, prog_data};
    wire bt_true = (opc_q[4] == tested_bit);

    wire [PC_W-1:0] pc_next = pc_q + {{(PC_W-1){1'b0}}, 1'b1};

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= ST_OPCODE;
            pc_q <= {PC_W{1'b0}};
            start_pc_q <= {PC_W{1'b0}};
            opc_q <= 8'h00;
            b2_q <= 8'h00;
            len_q <= `MID_LEN_1;
            cyc_q <= `MID_CYC_4;
            cls_q <= `MID_CLS_BAD;
            op_q <= `MID_OP_NONE;
            src_q <= `MID_SRC_NONE;
            z_upd_q <= 1'b0;
            c_upd_q <= 1'b0;
            timer_start_q <= 1'b0;
            exec_go_q <= 1'b0;
            exec_cls_q <= `MID_CLS_BAD;
            exec_op_q <= `MID_OP_NONE;
            exec_src_q <= `MID_SRC_NONE;
            exec_addr_q <= 8'h00;
            exec_imm_q <= 8'h00;
            exec_bit_q <= 3'h0;
            exec_target_q <= {PC_W{1'b0}};
            exec_z_upd_q <= 1'b0;
            exec_c_upd_q <= 1'b0;
            flag_z_q <= 1'b0;
            flag_c_q <= 1'b0;
        end
        else
        begin
            exec_go_q <= 1'b0;
            timer_start_q <= 1'b0;
            case (state_q)
                ST_OPCODE:
                begin
                    if (take)
                    begin
                        opc_q <= prog_data;
                        start_pc_q <= pc_q;
                        pc_q <= pc_next;
                        cls_q <= t_cls;
                        op_q <= t_op;
                        src_q <= t_src;
                        len_q <= t_len;
                        cyc_q <= t_cyc;
                        z_upd_q <= t_z_upd;
                        c_upd_q <= t_c_upd;
                        if (t_len == `MID_LEN_1)
                        begin
                            state_q <= ST_EXEC;
                            timer_start_q <= 1'b1;
                            exec_go_q <= 1'b1;
                            exec_cls_q <= t_cls;
                            exec_op_q <= t_op;
                            exec_src_q <= t_src;
                            exec_z_upd_q <= t_z_upd;
                            exec_c_upd_q <= t_c_upd;
                            exec_imm_q <= 8'h00;
                            // short-direct: X Y V W from opcode bits 7:6
                            if (t_src == `MID_SRC_SHORT)
                                exec_addr_q <= `MID_ADDR_X | {6'h00, prog_data[7:6]};
                            else if (t_src == `MID_SRC_INDIRECT)
                                exec_addr_q <= prog_data[4] ? `MID_ADDR_Y : `MID_ADDR_X;
                            else
                                exec_addr_q <= `MID_ADDR_ACC;
                        end
                        else
                            state_q <= ST_BYTE2;
                    end
                end
                ST_BYTE2:
                begin
                    if (take)
                    begin
                        b2_q <= prog_data;
                        pc_q <= pc_next;
                        if (len_q == `MID_LEN_3)
                            state_q <= ST_BYTE3;
                        else
                        begin
                            state_q <= ST_EXEC;
                            timer_start_q <= 1'b1;
                            exec_go_q <= 1'b1;
                            exec_cls_q <= cls_q;
                            exec_op_q <= op_q;
                            exec_src_q <= src_q;
                            exec_z_upd_q <= z_upd_q;
                            exec_c_upd_q <= c_upd_q;
                            exec_bit_q <= opc_q[7:5];
                            exec_addr_q <= prog_data;
                            exec_imm_q <= prog_data;
                            // 12-bit target from opcode high nibble and next byte
                            exec_target_q <= {opc_q[7:4], prog_data};
                            if (cls_q == `MID_CLS_JMP)
                                pc_q <= {opc_q[7:4], prog_data};
                        end
                    end
                end
                ST_BYTE3:
                begin
                    if (take)
                    begin
                        pc_q <= pc_next;
                        state_q <= ST_EXEC;
                        timer_start_q <= 1'b1;
                        exec_go_q <= 1'b1;
                        exec_cls_q <= cls_q;
                        exec_op_q <= op_q;
                        exec_src_q <= src_q;
                        exec_z_upd_q <= z_upd_q;
                        exec_c_upd_q <= c_upd_q;
                        exec_bit_q <= opc_q[7:5];
                        exec_addr_q <= b2_q;
                        exec_imm_q <= prog_data;
                        if (cls_q == `MID_CLS_BRANCH)
                        begin
                            // tested bit into carry; Z untouched
                            flag_c_q <= tested_bit;
                            if (bt_true)
                                pc_q <= pc_next + bt_disp;
                        end
                    end
                end
                default:
                begin
                    if (t_last)
                        state_q <= ST_OPCODE;
                    if (timer_start_q && op_q == `MID_OP_REL_BRANCH && rel_true)
                        pc_q <= rel_dest;
                    // datapath results land while executing; branches leave flags
                    if (t_busy && exec_z_upd_q && exec_z_wr)
                        flag_z_q <= exec_z;
                    if (t_busy && exec_c_upd_q && exec_c_wr && cls_q != `MID_CLS_BRANCH)
                        flag_c_q <= exec_c;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

//--- rtl/mid_opcode_table.v
// mid_opcode_table.v: combinational opcode classifier
// assumes: opcode is the first program byte of an instruction
`timescale 1ns/1ns
`default_nettype none

module mid_opcode_table
(
    input wire [7:0] opcode,
    output reg [2:0] cls,
    output reg [4:0] op,
    output reg [2:0] src,
    output reg [1:0] len,
    output reg [2:0] cycles,
    output reg z_upd,
    output reg c_upd
);
`include "mid_regs.vh"

    wire [3:0] lo = opcode[3:0];
    wire [3:0] hi = opcode[7:4];

    always @*
    begin
        cls = `MID_CLS_BAD;
        op = `MID_OP_NONE;
        src = `MID_SRC_NONE;
        len = `MID_LEN_1;
        cycles = `MID_CYC_4;
        z_upd = 1'b0;
        c_upd = 1'b0;
        // low three bits select the column of the map
        case (lo[2:0])
            3'h0, 3'h2, 3'h4, 3'h6:
            begin
                // relative branches: one byte, two cycles, no flags
                cls = `MID_CLS_BRANCH;
                op = `MID_OP_REL_BRANCH;
                cycles = `MID_CYC_2;
                if (lo == 4'h4 && hi == 4'h0)
                begin
                    cls = `MID_CLS_CTRL;
                    op = `MID_OP_NOP;
                end
            end
            3'h1:
            begin
                // extended addressing carries 12 bits of target
                cls = `MID_CLS_JMP;
                op = lo[3] ? `MID_OP_JUMP : `MID_OP_CALL;
                len = `MID_LEN_2;
            end
            3'h3:
            begin
                if (!lo[3])
                begin
                    cls = `MID_CLS_BRANCH;
                    op = hi[0] ? `MID_OP_BIT_SET_BR : `MID_OP_BIT_CLR_BR;
                    len = `MID_LEN_3;
                    cycles = `MID_CYC_5;
                    c_upd = 1'b1;
                end
                else
                begin
                    cls = `MID_CLS_BIT;
                    op = hi[0] ? `MID_OP_BIT_SET : `MID_OP_BIT_RES;
                    len = `MID_LEN_2;
                end
            end
            3'h5:
            begin
                // short direct group and inherent ops
                z_upd = 1'b1;
                src = `MID_SRC_SHORT;
                case (hi[1:0])
                    2'h1:
                    begin
                        cls = `MID_CLS_ALU;
                        op = `MID_OP_BUMP_UP;
                    end
                    2'h3:
                    begin
                        cls = `MID_CLS_ALU;
                        op = `MID_OP_BUMP_DOWN;
                    end
                    default:
                    begin
                        cls = `MID_CLS_LDST;
                        op = `MID_OP_MOVE_ACCUM;
                    end
                endcase
                if (lo[3] && hi[1:0] == 2'h0)
                begin
                    cls = `MID_CLS_CTRL;
                    src = `MID_SRC_NONE;
                    z_upd = 1'b0;
                    case (hi[3:2])
                        2'h0: op = `MID_OP_RET;
                        2'h1: op = `MID_OP_RETI;
                        2'h2: op = `MID_OP_STOP;
                        default: op = `MID_OP_WAIT;
                    endcase
                    cycles = `MID_CYC_2;
                    z_upd = (hi[3:2] == 2'h1);
                    c_upd = (hi[3:2] == 2'h1);
                end
                else if (lo[3] && hi[1:0] == 2'h2)
                begin
                    cls = `MID_CLS_ALU;
                    src = `MID_SRC_ACC;
                    c_upd = 1'b1;
                    case (hi[3:2])
                        2'h0: op = `MID_OP_INVERT;
                        2'h1: op = `MID_OP_ROTATE;
                        default:
                        begin
                            op = `MID_OP_SHIFT_LEFT;
                            len = `MID_LEN_2;
                        end
                    endcase
                end
            end
            default:
            begin
                // column 7/f: accumulator ops, indirect/immediate/direct by bits
                src = lo[3] ? `MID_SRC_DIRECT : `MID_SRC_INDIRECT;
                len = lo[3] ? `MID_LEN_2 : `MID_LEN_1;
                z_upd = 1'b1;
                c_upd = 1'b1;
                cls = `MID_CLS_ALU;
                case (hi[3:1])
                    3'h0:
                    begin
                        cls = `MID_CLS_LDST;
                        op = `MID_OP_MOVE_ACCUM;
                        c_upd = 1'b0;
                    end
                    3'h1: op = `MID_OP_COMPARE;
                    3'h2: op = `MID_OP_ADD;
                    3'h3:
                    begin
                        op = `MID_OP_BUMP_UP;
                        c_upd = 1'b0;
                    end
                    3'h4: op = `MID_OP_AND;
                    3'h5: op = `MID_OP_SUB;
                    3'h6:
                    begin
                        op = `MID_OP_BUMP_DOWN;
                        c_upd = 1'b0;
                    end
                    default:
                    begin
                        cls = `MID_CLS_LDST;
                        op = `MID_OP_MOVE_ACCUM;
                        c_upd = 1'b0;
                    end
                endcase
                // odd rows of the accumulator ops, except rows 7, D and F, take immediate data
                if (hi[0] && hi[3:1] != 3'h3 && hi[3:1] != 3'h6 && hi[3:1] != 3'h7)
                begin
                    src = `MID_SRC_IMM;
                    len = `MID_LEN_2;
                    if (hi[3:1] == 3'h0)
                        op = `MID_OP_MOVE_IMMEDIATE;
                end
                // direct-column immediate load into any data register
                if (lo[3] && hi == 4'h0)
                begin
                    op = `MID_OP_MOVE_IMMEDIATE;
                    src = `MID_SRC_IMM;
                    len = `MID_LEN_3;
                    z_upd = 1'b0;
                    c_upd = 1'b0;
                end
                // zero fill of a direct register, three bytes, no flags
                if (lo[3] && hi == 4'hE)
                begin
                    op = `MID_OP_ZERO_FILL;
                    src = `MID_SRC_DIRECT;
                    len = `MID_LEN_3;
                    z_upd = 1'b0;
                    c_upd = 1'b0;
                end
            end
        endcase
    end
endmodule

`default_nettype wire

//--- rtl/mid_regs.vh
// mid_regs.vh: opcode fields, instruction classes, lengths, cycle counts
// assumes: included by the decoder files, defines only
`ifndef MID_REGS_VH
`define MID_REGS_VH

// instruction classes
`define MID_CLS_LDST 3'h0
`define MID_CLS_ALU 3'h1
`define MID_CLS_BRANCH 3'h2
`define MID_CLS_CTRL 3'h3
`define MID_CLS_JMP 3'h4
`define MID_CLS_BIT 3'h5
`define MID_CLS_BAD 3'h7

// operation codes driven to the datapath
`define MID_OP_NONE 5'h00
`define MID_OP_MOVE_ACCUM 5'h01
`define MID_OP_MOVE_IMMEDIATE 5'h02
`define MID_OP_ADD 5'h03
`define MID_OP_AND 5'h04
`define MID_OP_COMPARE 5'h05
`define MID_OP_SUB 5'h06
`define MID_OP_ZERO_FILL 5'h07
`define MID_OP_BUMP_UP 5'h08
`define MID_OP_BUMP_DOWN 5'h09
`define MID_OP_INVERT 5'h0A
`define MID_OP_ROTATE 5'h0B
`define MID_OP_SHIFT_LEFT 5'h0C
`define MID_OP_REL_BRANCH 5'h0D
`define MID_OP_BIT_CLR_BR 5'h0E
`define MID_OP_BIT_SET_BR 5'h0F
`define MID_OP_BIT_SET 5'h10
`define MID_OP_BIT_RES 5'h11
`define MID_OP_JUMP 5'h12
`define MID_OP_CALL 5'h13
`define MID_OP_NOP 5'h14
`define MID_OP_RET 5'h15
`define MID_OP_RETI 5'h16
`define MID_OP_STOP 5'h17
`define MID_OP_WAIT 5'h18

// operand sources
`define MID_SRC_NONE 3'h0
`define MID_SRC_ACC 3'h1
`define MID_SRC_SHORT 3'h2
`define MID_SRC_DIRECT 3'h3
`define MID_SRC_INDIRECT 3'h4
`define MID_SRC_IMM 3'h5

// relative branch conditions, opcode bits 2:1 of low nibble pattern
`define MID_COND_ZCLR 2'h0
`define MID_COND_CCLR 2'h1
`define MID_COND_ZSET 2'h2
`define MID_COND_CSET 2'h3

// encoded lengths and cycle counts
`define MID_LEN_1 2'h1
`define MID_LEN_2 2'h2
`define MID_LEN_3 2'h3
`define MID_CYC_2 3'h2
`define MID_CYC_4 3'h4
`define MID_CYC_5 3'h5

// data space short-direct and indirect registers, and the accumulator
`define MID_ADDR_X 8'h80
`define MID_ADDR_Y 8'h81
`define MID_ADDR_V 8'h82
`define MID_ADDR_W 8'h83
`define MID_ADDR_ACC 8'hFF

`endif
